/* logic/sfc_unit.sv */
// spi unit with fifos, master pacing by select and ready, slave by select input
//
// Notes on behaviour
// (RQ1) master paces fifo transfers with select output low and ready input low
// (RQ2) master may instead run at a fixed rate from the sample period setting
// (RQ3) slave: select input loads transmit bits and latches received bits
// (RQ4) slave: select input steps fifo pointers, one step per completed word
// (RQ5) slave phase, polarity and word length follow the control settings
// (RQ6) master ready trigger: edge, level, or ignored
// (RQ7) slave fifo advance: on bit count reached or on select rising edge
// (RQ8) select goes low no sooner than two clocks after ready active
// (RQ9) at least three bit clocks from select low to first shift edge
// (RQ10) select held low at least two bit clocks after last shift edge
// (RQ11) peer keeps ready until select has risen
// (RQ12) select high gap at least one bit clock plus the wait count; in reference clocks the unit waits for the later of the two
// (RQ13) wait count in bit clocks or in 32.768 khz reference clocks
// (RQ14) external master drives select low a clock before first edge
// (RQ15) external master holds each select pulse at least one clock
// (RQ16) clock limits refer to the unit's own peripheral clock
// (RQ17) after reset select high, fifos empty, no shift edges until enabled
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.svh"

module sfc_unit (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire sfc_pkg::sfc_ctrl_t ctrl,
	input wire sfc_pkg::sfc_period_t period,
	input wire logic overrun_clr,
	output sfc_pkg::sfc_status_t status,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [15:0] tx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [15:0] rx_data,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic ss_in_n,
	output logic ss_out_n,
	output logic ss_oe,
	input wire logic spi_rdy_n,
	input wire logic ref_32k
);
	import sfc_pkg::*;

	sfc_state_t state;
	sfc_state_t next_state;
	logic [5:0] pin_m;
	logic [5:0] pin_s;
	logic [5:0] pin_d;
	logic [7:0] div;
	logic [16:0] cnt;
	logic [14:0] wcnt;
	logic [4:0] ecnt;
	logic rdy_seen;
	logic sclk_ph;
	logic sclk_q;
	logic ss_n;
	logic [15:0] tx_sh;
	logic [15:0] rx_sh;
	logic out_bit;
	logic reload;
	logic word_done;
	logic rx_ovr;
	logic tx_rd_valid;
	logic [15:0] tx_rd_data;
	logic rx_wr_ready;

	// synchronised pins read from the second stage, their edges from the second and third stages
	wire miso_s = pin_s[0];
	wire mosi_s = pin_s[1];
	wire ssn_s = pin_s[3];
	wire rdyn_s = pin_s[4];
	wire sclk_edge = pin_s[2] ^ pin_d[2];
	wire ss_fall = !ssn_s && pin_d[3];
	wire ss_rise = ssn_s && !pin_d[3];
	wire rdy_fall = !rdyn_s && pin_d[4];
	wire ref_rise = pin_s[5] && !pin_d[5];

	// mode decode
	wire en_m = ctrl.enable && ctrl.master;
	wire en_s = ctrl.enable && !ctrl.master;
	wire slave_act = en_s && !ssn_s;
	wire adv_bitcnt = ctrl.adv_mode == `SFC_ADV_BITCNT;
	wire in_run = state != SFC_IDLE && state != SFC_RDY_WAIT;

	// half bit clock tick, never faster than the 10 mhz limit
	wire [7:0] half_term = (ctrl.clk_div < 8'(`SFC_HALF_MIN_TERM)) ?
		8'(`SFC_HALF_MIN_TERM) : ctrl.clk_div;
	wire half_tick = in_run && div == half_term;

	// ready trigger qualification
	wire rdy_ok = (ctrl.ready_mode == `SFC_RDY_IGNORE) ||
		(ctrl.ready_mode == `SFC_RDY_LEVEL && !rdyn_s) ||
		(ctrl.ready_mode == `SFC_RDY_EDGE && rdy_seen); // [RQ6] [RQ1]
	wire go = state == SFC_RDY_WAIT && rdy_ok &&
		cnt >= 17'(`SFC_RDY_SS_CYC); // [RQ8] [RQ16]

	// gap end: one bit clock plus wait in bit clocks, or the later of one bit clock and the wait in reference clocks
	wire [16:0] gap_bits = 17'(`SFC_GAP_HALF) + {1'b0, period.wait_count, 1'b0};
	wire gap_done = cnt >= 17'(`SFC_GAP_HALF) && (period.ref_sel ?
		wcnt >= period.wait_count : cnt >= gap_bits); // [RQ12] [RQ13] [RQ2]

	// bit edges from own clock as master or from the pin as slave
	wire m_edge = state == SFC_SHIFT && half_tick;
	wire s_edge = slave_act && sclk_edge; // [RQ14]
	wire bit_edge = m_edge || s_edge;
	wire sample = bit_edge && (ecnt[0] == ctrl.cpha); // [RQ5]
	wire drive = bit_edge && (ecnt[0] != ctrl.cpha); // [RQ5]
	wire last_edge = ecnt == {ctrl.bit_count, 1'b1};
	wire s_word = s_edge && last_edge && adv_bitcnt; // [RQ7]
	wire s_rise_adv = en_s && ss_rise && !adv_bitcnt; // [RQ7] [RQ15]

	// shift register loading and fifo steps
	wire load = go || (en_s && ss_fall) || reload; // [RQ3]
	wire [15:0] tx_word = tx_rd_valid ? tx_rd_data : 16'h0000;
	wire [15:0] aligned = tx_word << (4'hf - ctrl.bit_count);
	wire tx_pop = go || s_word || s_rise_adv; // [RQ4]
	wire rx_push = word_done || s_rise_adv; // [RQ4]
	wire [15:0] rx_word = rx_sh & (16'hffff >> (4'hf - ctrl.bit_count));
	wire din = ctrl.master ? miso_s : mosi_s;

	// pad enables and levels
	assign sclk_oe = en_m;
	assign mosi_oe = en_m;
	assign ss_oe = en_m;
	assign miso_oe = slave_act;
	assign sclk_out = sclk_q;
	assign mosi_out = out_bit;
	assign miso_out = out_bit;
	assign ss_out_n = ss_n;

	sfc_fifo u_tx_fifo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.wr_valid(tx_valid),
		.wr_ready(tx_ready),
		.wr_data(tx_data),
		.rd_valid(tx_rd_valid),
		.rd_ready(tx_pop),
		.rd_data(tx_rd_data)
	);

	sfc_fifo u_rx_fifo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.wr_valid(rx_push),
		.wr_ready(rx_wr_ready),
		.wr_data(rx_word),
		.rd_valid(rx_valid),
		.rd_ready(rx_ready),
		.rd_data(rx_data)
	);

	// two-flop synchroniser plus edge history
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pin_m <= 6'h3f;
			pin_s <= 6'h3f;
			pin_d <= 6'h3f;
		end else begin
			pin_m <= {ref_32k, spi_rdy_n, ss_in_n, sclk_in, mosi_in, miso_in};
			pin_s <= pin_m;
			pin_d <= pin_s;
		end
	end

	// master sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			SFC_IDLE: if (en_m && tx_rd_valid) next_state = SFC_RDY_WAIT; // [RQ17]
			SFC_RDY_WAIT: begin
				if (!en_m) begin
					next_state = SFC_IDLE;
				end else if (go) begin
					next_state = SFC_SS_LEAD;
				end
			end
			SFC_SS_LEAD: begin
				if (half_tick && cnt == 17'(`SFC_LEAD_HALF - 1)) next_state = SFC_SHIFT; // [RQ9]
			end
			SFC_SHIFT: if (m_edge && last_edge) next_state = SFC_SS_TRAIL;
			SFC_SS_TRAIL: begin
				if (half_tick && cnt == 17'(`SFC_TRAIL_HALF - 1)) next_state = SFC_SS_GAP; // [RQ10]
			end
			SFC_SS_GAP: if (gap_done) next_state = SFC_IDLE; // [RQ12]
			default: next_state = SFC_IDLE;
		endcase
	end

	// state, select line and bit clock level
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= SFC_IDLE;
			ss_n <= 1'b1;
			sclk_ph <= 1'b0;
			sclk_q <= 1'b0;
		end else begin
			state <= next_state;
			ss_n <= !(next_state == SFC_SS_LEAD || next_state == SFC_SHIFT ||
				next_state == SFC_SS_TRAIL); // [RQ1] [RQ17]
			sclk_ph <= in_run ? (sclk_ph ^ m_edge) : 1'b0;
			sclk_q <= ctrl.cpol ^ (in_run ? (sclk_ph ^ m_edge) : 1'b0);
		end
	end

	// divider, phase counter and reference clock counter
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			div <= 8'h00;
			cnt <= 17'h00000;
			wcnt <= 15'h0000;
		end else begin
			div <= (!in_run || half_tick) ? 8'h00 : div + 8'h01;
			if (next_state != state) begin
				cnt <= 17'h00000;
			end else if (state == SFC_RDY_WAIT) begin
				cnt <= rdy_ok ? cnt + 17'h00001 : 17'h00000; // [RQ8]
			end else begin
				cnt <= cnt + 17'(half_tick);
			end
			if (state != SFC_SS_GAP) begin
				wcnt <= 15'h0000;
			end else if (ref_rise && wcnt != 15'h7fff) begin
				wcnt <= wcnt + 15'h0001; // [RQ13]
			end
		end
	end

	// ready edge latch, a new edge wins over the consume
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdy_seen <= 1'b0;
		end else begin
			rdy_seen <= rdy_fall || (rdy_seen && !go); // [RQ6] [RQ11]
		end
	end

	// shift registers shared by master and slave
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tx_sh <= 16'h0000;
			rx_sh <= 16'h0000;
			out_bit <= 1'b0;
			ecnt <= 5'h00;
			reload <= 1'b0;
			word_done <= 1'b0;
		end else begin
			reload <= s_word; // [RQ7]
			word_done <= (m_edge || s_word) && last_edge;
			if (load) begin
				tx_sh <= ctrl.cpha ? aligned : {aligned[14:0], 1'b0}; // [RQ3]
				out_bit <= ctrl.cpha ? 1'b0 : aligned[15];
				ecnt <= 5'h00;
			end else begin
				if (sample) rx_sh <= {rx_sh[14:0], din}; // [RQ3]
				if (drive) begin
					out_bit <= tx_sh[15];
					tx_sh <= {tx_sh[14:0], 1'b0};
				end
				if (bit_edge) ecnt <= s_word ? 5'h00 : ecnt + 5'h01;
			end
		end
	end

	// overrun flag and status, set wins over clear
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_ovr <= 1'b0;
			status <= '{busy: 1'b0, tx_empty: 1'b1, tx_full: 1'b0,
				rx_empty: 1'b1, rx_full: 1'b0, rx_overrun: 1'b0}; // [RQ17]
		end else begin
			rx_ovr <= (rx_push && !rx_wr_ready) || (rx_ovr && !overrun_clr);
			status <= '{busy: in_run || slave_act, tx_empty: !tx_rd_valid,
				tx_full: !tx_ready, rx_empty: !rx_valid, rx_full: !rx_wr_ready,
				rx_overrun: rx_ovr};
		end
	end

endmodule : sfc_unit
`default_nettype wire

/* logic/sfc_defines.svh */
// constants for the spi flow-control unit
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

`define SFC_CLK_PERIOD_NS 10
`define SFC_WORD_W 16
`define SFC_FIFO_DEPTH 8
`define SFC_FIFO_AW 3
`define SFC_PIN_W 6

// ready-input trigger modes
`define SFC_RDY_EDGE 2'h0
`define SFC_RDY_LEVEL 2'h1
`define SFC_RDY_IGNORE 2'h2

// slave fifo advance modes
`define SFC_ADV_BITCNT 1'h0
`define SFC_ADV_SSRISE 1'h1

// ready active to select low, least time
`define SFC_RDY_SS_MIN_NS 20
`define SFC_RDY_SS_CYC ((`SFC_RDY_SS_MIN_NS + `SFC_CLK_PERIOD_NS - 1) / `SFC_CLK_PERIOD_NS)
// bit clock no faster than 10 mhz
`define SFC_SCLK_MIN_PERIOD_NS 100
`define SFC_HALF_MIN_CYC ((`SFC_SCLK_MIN_PERIOD_NS / 2 + `SFC_CLK_PERIOD_NS - 1) / `SFC_CLK_PERIOD_NS)
`define SFC_HALF_MIN_TERM (`SFC_HALF_MIN_CYC - 1)
// select timing in half bit clocks
`define SFC_LEAD_HALF 6
`define SFC_TRAIL_HALF 4
`define SFC_GAP_HALF 2

`endif

/* logic/sfc_pkg.sv */
// types for the spi flow-control unit
package sfc_pkg;

	// unit control register
	typedef struct packed {
		logic enable;
		logic master;
		logic cpol;
		logic cpha;
		logic [1:0] ready_mode;
		logic adv_mode;
		logic [3:0] bit_count;
		logic [7:0] clk_div;
	} sfc_ctrl_t;

	// sample period register
	typedef struct packed {
		logic ref_sel;
		logic [14:0] wait_count;
	} sfc_period_t;

	typedef struct packed {
		logic busy;
		logic tx_empty;
		logic tx_full;
		logic rx_empty;
		logic rx_full;
		logic rx_overrun;
	} sfc_status_t;

	typedef enum logic [2:0] {
		SFC_IDLE = 3'h0,
		SFC_RDY_WAIT = 3'h1,
		SFC_SS_LEAD = 3'h2,
		SFC_SHIFT = 3'h3,
		SFC_SS_TRAIL = 3'h4,
		SFC_SS_GAP = 3'h5
	} sfc_state_t;

endpackage : sfc_pkg

/* logic/sfc_fifo.sv */
// word fifo held in flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.svh"

module sfc_fifo #(
	parameter int W = `SFC_WORD_W,
	parameter int D = `SFC_FIFO_DEPTH,
	parameter int AW = `SFC_FIFO_AW
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [W-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [W-1:0] rd_data
);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	wire do_wr = wr_valid && wr_ready;
	wire do_rd = rd_valid && rd_ready;

	// honest full and empty from the fill count
	assign wr_ready = cnt != (AW+1)'(D);
	assign rd_valid = cnt != '0;
	assign rd_data = mem[rp];

	// pointers and count
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= wp + AW'(do_wr);
			rp <= rp + AW'(do_rd);
			cnt <= cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk_sys) begin
		if (do_wr) begin
			mem[wp] <= wr_data;
		end
	end

endmodule : sfc_fifo
`default_nettype wire

/* testbench/sfc_unit_chk.sv */
// timing checker for the spi unit select and shift clock
`timescale 1ns/1ps
`default_nettype none
module sfc_unit_chk (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire sfc_pkg::sfc_ctrl_t ctrl,
	input wire sfc_pkg::sfc_period_t period,
	input wire sfc_pkg::sfc_status_t status,
	input wire logic sclk_out,
	input wire logic ss_out_n,
	input wire logic spi_rdy_n
);
	import sfc_pkg::*;
	logic sclk_d;
	int lo, hi, since, edges, h;
	wire logic tog = sclk_out != sclk_d;
	assign h = 32'(ctrl.clk_div) + 1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// cycles low, high, since a shift edge, edges in a frame
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sclk_d <= 1'b0;
			lo <= 0;
			hi <= 100000;
			since <= 0;
			edges <= 0;
		end else begin
			sclk_d <= sclk_out;
			lo <= ss_out_n ? 0 : lo + 1;
			hi <= ss_out_n ? hi + 1 : 0;
			since <= tog ? 1 : since + 1;
			edges <= ss_out_n ? 0 : edges + 32'(tog);
		end
	end
	a_rst_idle: assert property ($rose(resetn) |-> ss_out_n && status.tx_empty)
		else $error("busy after reset");
	a_rdy_lead: assert property ($fell(ss_out_n) && ctrl.ready_mode != 2'h2 |-> !$past(spi_rdy_n, 2))
		else $error("select before ready");
	a_first_edge: assert property (tog && !ss_out_n && edges == 0 |-> lo >= 6 * h)
		else $error("first edge early");
	a_trail_hold: assert property ($rose(ss_out_n) |-> since >= 4 * h)
		else $error("select rose early");
	a_gap_len: assert property ($fell(ss_out_n) |-> hi >= (period.ref_sel ? 2 : 2 + 2 * period.wait_count) * h)
		else $error("gap short");
	a_edge_cnt: assert property ($rose(ss_out_n) |-> edges == 2 * (ctrl.bit_count + 1))
		else $error("edge count wrong");
	a_idle_still: assert property (ctrl.master && ss_out_n && $past(ss_out_n) && ctrl == $past(ctrl) && ctrl == $past(ctrl, 2) |-> $stable(sclk_out))
		else $error("clock moved idle");
	a_no_start: assert property (ctrl.ready_mode == 2'h3 && $past(ctrl.ready_mode) == 2'h3 && ss_out_n |=> ss_out_n)
		else $error("started in mode 3");
endmodule : sfc_unit_chk
bind sfc_unit sfc_unit_chk u_chk (.clk_sys, .resetn, .ctrl, .period, .status, .sclk_out, .ss_out_n, .spi_rdy_n);
`default_nettype wire

/* testbench/sfc_peer.sv */
// far-side spi peer: slave to the unit's master, master to the unit's slave
`timescale 1ns/1ps
`default_nettype none
module sfc_peer (
	input wire logic clk_sys,
	input wire logic sclk_out,
	input wire logic mosi_out,
	input wire logic miso_out,
	input wire logic ss_out_n,
	input wire logic rdy_want,
	input wire logic [3:0] nbit,
	input wire logic [15:0] ptx,
	output logic spi_rdy_n,
	output logic miso_in,
	output logic sclk_in,
	output logic mosi_in,
	output logic ss_in_n,
	output logic [15:0] prx
);
	logic [15:0] sh;
	// idle pins
	initial begin
		spi_rdy_n = 1'b1;
		miso_in = 1'b0;
		sclk_in = 1'b0;
		mosi_in = 1'b0;
		ss_in_n = 1'b1;
	end
	// ready kept low until select rises
	always @(posedge clk_sys) spi_rdy_n <= (!ss_out_n && !spi_rdy_n) ? 1'b0 : !rdy_want;
	// slave role, mode 0: load at select fall, sample rising, shift falling
	always @(negedge ss_out_n) sh = ptx;
	always @(posedge sclk_out) if (!ss_out_n) prx = {prx[14:0], mosi_out};
	always @(negedge sclk_out) if (!ss_out_n) sh = sh << 1;
	// released line flips to the inverse of its last level
	always @(ss_out_n, sh) miso_in = ss_out_n ? !miso_in : sh[nbit];
	// master role with a 125 ns link clock
	task automatic frame(input logic [15:0] w, input int nb, input logic pol, input logic pha,
		output logic [15:0] r);
		r = 16'h0000;
		sclk_in = pol;
		#100 ss_in_n = 1'b0;
		#200;
		for (int i = nb - 1; i >= 0; i--) begin
			if (!pha) mosi_in = w[i];
			#62.5 sclk_in = !pol;
			if (pha) mosi_in = w[i];
			else r = {r[14:0], miso_out};
			#62.5 sclk_in = pol;
			if (pha) r = {r[14:0], miso_out};
		end
		#200;
	endtask : frame
	task automatic frame_end();
		ss_in_n = 1'b1;
		mosi_in = !mosi_in;
		#200;
	endtask : frame_end
endmodule : sfc_peer
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the spi flow-control unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
	import sfc_pkg::*;
	sfc_ctrl_t ctrl;
	sfc_period_t period;
	sfc_status_t status;
	logic clk_sys, resetn, tx_valid, tx_ready, rx_valid, rx_ready, rdy_want, ref_32k;
	logic sclk_out, mosi_out, miso_in, miso_out, sclk_in, mosi_in, ss_in_n, ss_out_n, spi_rdy_n;
	logic ss_oe, miso_oe;
	logic [15:0] tx_data, rx_data, prx, ptx, w, w2, r, got;
	logic [31:0] seed = 32'h42f37d78;
	int num_errors = 0, n_tests = 0, nb;
	int modes[4] = '{3, 0, 1, 2};
	sfc_unit dut (.clk_sys, .resetn, .ctrl, .period, .overrun_clr(1'b0), .status, .tx_valid,
		.tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data, .sclk_in, .sclk_out, .sclk_oe(),
		.mosi_in, .mosi_out, .mosi_oe(), .miso_in, .miso_out, .miso_oe, .ss_in_n, .ss_out_n,
		.ss_oe, .spi_rdy_n, .ref_32k);
	sfc_peer peer (.clk_sys, .sclk_out, .mosi_out, .miso_out, .ss_out_n, .rdy_want,
		.nbit(ctrl.bit_count), .ptx, .spi_rdy_n, .miso_in, .sclk_in, .mosi_in, .ss_in_n, .prx);
	// clocks
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		ref_32k = 1'b0;
		forever #15259 ref_32k = ~ref_32k;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [15:0] mask(input logic [15:0] v, input int n);
		return v & 16'((32'h1 << n) - 32'h1);
	endfunction : mask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	// k 0 rx word, 1 select low, 2 select high
	task automatic waitv(input int k);
		int n;
		n = 0;
		while ((k == 0 ? rx_valid : k == 1 ? !ss_out_n : ss_out_n) !== 1'b1) begin
			@(negedge clk_sys);
			n++;
			if (n > 20000) begin
				num_errors++;
				finish_test();
			end
		end
	endtask : waitv
	task automatic push(input logic [15:0] a, input logic [15:0] b, input int n);
		@(posedge clk_sys);
		tx_valid <= 1'b1;
		tx_data <= a;
		if (n > 1) begin
			@(posedge clk_sys);
			tx_data <= b;
		end
		@(posedge clk_sys);
		tx_valid <= 1'b0;
	endtask : push
	task automatic pop(output logic [15:0] v);
		waitv(0);
		v = rx_data;
		@(posedge clk_sys);
		rx_ready <= 1'b1;
		@(posedge clk_sys);
		rx_ready <= 1'b0;
	endtask : pop
	// master frames per ready mode, then slave frames per clock mode
	initial begin
		resetn = 1'b0;
		ctrl = '0;
		period = '0;
		tx_valid = 1'b0;
		tx_data = 16'h0000;
		rx_ready = 1'b0;
		rdy_want = 1'b0;
		ptx = 16'h0000;
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		@(negedge clk_sys);
		`CHK("ss_idle", 1'b1, ss_out_n)
		`CHK("empty", 2'b11, {status.tx_empty, status.rx_empty})
		for (int i = 0; i < 4; i++) begin
			nb = 8 + int'(rnd() % 9);
			w = rnd();
			w2 = rnd();
			@(posedge clk_sys);
			ptx <= rnd();
			ctrl <= '{1'b1, 1'b1, 1'b0, 1'b0, 2'(modes[i]), 1'b0, 4'(nb - 1), 8'h04};
			period <= '{i == 2, 15'(rnd() % 4)};
			rdy_want <= modes[i] < 2;
			push(w, w2, 2);
			if (modes[i] == 3) begin
				repeat (200) @(posedge clk_sys);
				`CHK("no_start", 1'b1, ss_out_n)
				ctrl.ready_mode <= 2'h2;
			end
			waitv(1);
			`CHK("ss_drive", 1'b1, ss_oe)
			waitv(2);
			`CHK("peer_rx", mask(w, nb), mask(prx, nb))
			@(posedge clk_sys);
			rdy_want <= 1'b0;
			repeat (3) @(posedge clk_sys);
			rdy_want <= 1'b1;
			pop(got);
			`CHK("rx1", mask(ptx, nb), got)
			waitv(1);
			waitv(2);
			`CHK("peer_rx2", mask(w2, nb), mask(prx, nb))
			pop(got);
			`CHK("rx2", mask(ptx, nb), got)
			@(posedge clk_sys);
			rdy_want <= 1'b0;
			$display("master mode %0d done", modes[i]);
		end
		for (int k = 0; k < 4; k++) begin
			nb = 8 + int'(rnd() % 9);
			w = rnd();
			w2 = rnd();
			@(posedge clk_sys);
			ctrl <= '{1'b1, 1'b0, k[0], k[1], 2'h0, k[0], 4'(nb - 1), 8'h04};
			push(w, w, 1);
			repeat (4) @(posedge clk_sys);
			peer.frame(w2, nb, k[0], k[1], r);
			@(negedge clk_sys);
			`CHK("adv_early", !k[0], rx_valid)
			`CHK("ss_input", 2'b01, {ss_oe, miso_oe})
			peer.frame_end();
			pop(got);
			`CHK("slv_rx", mask(w2, nb), got)
			`CHK("slv_tx", mask(w, nb), r)
			`CHK("tx_step", 1'b1, status.tx_empty)
			$display("slave mode %0d done", k);
		end
		finish_test();
	end
endmodule : tb
`default_nettype wire
